// ---- rtl/slc_led_ctrl.sv ----
// Status indicator output control: polarity, force, blink and stretch
//
// Function
// - Aux output active level from polarity bit 14; reset high.
// - Bit 12 set forces aux output to bit 13 value.
// - Indicator two active level from bit 10; reset high.
// - Bit 8 set forces indicator two to bit 9 value.
// - Indicator one active level from bit 6; reset high.
// - Bit 4 set forces indicator one to bit 5 value.
// - Indicator zero active level from bit 2; reset high.
// - Bit 0 set forces indicator zero to bit 1 value.
// - Blink register bit 2 bypasses activity stretching; reset clear.
// - Two-bit rate picks 50, 100, 200 or 500 ms; reset 10.
// - Each output takes normal value from a four-bit source field.
// - Source codes map link, activity, collision, duplex, errors; 5h gigabit.
`timescale 1ns/10ps
module slc_led_ctrl
  import slc_pkg::*;
#(
  parameter int unsigned BLINK_CYC_20HZ = slc_pkg::SLC_CYC_20HZ,
  parameter int unsigned BLINK_CYC_10HZ = slc_pkg::SLC_CYC_10HZ,
  parameter int unsigned BLINK_CYC_5HZ = slc_pkg::SLC_CYC_5HZ,
  parameter int unsigned BLINK_CYC_2HZ = slc_pkg::SLC_CYC_2HZ,
  parameter int unsigned CNT_W = slc_pkg::SLC_CNT_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [slc_pkg::SLC_ADDR_W-1:0] reg_addr,
  input wire logic [slc_pkg::SLC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [slc_pkg::SLC_DATA_W-1:0] reg_rdata,
  input wire logic link_up_1000,
  input wire logic link_up_100,
  input wire logic link_up_10,
  input wire logic copper_link,
  input wire logic full_duplex,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic collision,
  input wire logic rx_error,
  input wire logic tx_error,
  output logic indicator_zero_pin,
  output logic indicator_one_pin,
  output logic indicator_two_pin,
  output logic aux_indicator_pin
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 31) begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end
  if (BLINK_CYC_20HZ < 2 || BLINK_CYC_10HZ < 2 || BLINK_CYC_5HZ < 2
      || BLINK_CYC_2HZ < 2) begin : g_bad_short
    $error("blink period below two cycles");
  end
  if (BLINK_CYC_20HZ >= (1 << CNT_W) || BLINK_CYC_10HZ >= (1 << CNT_W)
      || BLINK_CYC_5HZ >= (1 << CNT_W) || BLINK_CYC_2HZ >= (1 << CNT_W)) begin : g_bad_long
    $error("blink period does not fit CNT_W");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] source_select_q;
  logic [15:0] pol_force_q;
  logic [15:0] blink_stretch_q;
  logic [15:0] rdata_q;
  logic [3:0] pin_q;
  logic [3:0] pin_d;
  logic [CNT_W-1:0] period_cyc;
  logic [CNT_W-1:0] tmr_q;
  logic blink_wave;
  logic pulse_stretch_bypass;
  logic [1:0] blink_period_select;
  logic [SLC_NUM_EVT-1:0] evt_raw;
  logic [SLC_NUM_EVT-1:0] evt_str;
  logic link_ok;
  logic [4:0] status_vec;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Select one bit of an output's nibble
  function automatic logic nib_bit(input logic [15:0] r, input int unsigned idx,
                                   input int unsigned ofs);
    nib_bit = r[idx * SLC_FIELD_STRIDE + ofs];
  endfunction

  // Source code to status level
  // Status order: {copper, duplex, 10M, 100M, 1000M}
  function automatic logic src_level(input logic [3:0] code, input logic lnk,
                                     input logic [4:0] st,
                                     input logic [SLC_NUM_EVT-1:0] ev,
                                     input logic blink);
    logic lvl;
    lvl = 1'b0;
    case (code)
      SLC_SRC_LINK_OK: lvl = lnk;
      SLC_SRC_RXTX_ACT: lvl = ev[SLC_EVT_RX] | ev[SLC_EVT_TX];
      SLC_SRC_TX_ACT: lvl = ev[SLC_EVT_TX];
      SLC_SRC_RX_ACT: lvl = ev[SLC_EVT_RX];
      SLC_SRC_COLLISION: lvl = ev[SLC_EVT_COL];
      SLC_SRC_LINK_1000: lvl = st[0];
      SLC_SRC_LINK_100: lvl = st[1];
      SLC_SRC_LINK_10: lvl = st[2];
      SLC_SRC_LINK_10_100: lvl = st[2] | st[1];
      SLC_SRC_LINK_100_1000: lvl = st[1] | st[0];
      SLC_SRC_FULL_DUPLEX: lvl = st[3];
      SLC_SRC_COPPER_BLINK: begin
        lvl = lnk & st[4] & ~((ev[SLC_EVT_RX] | ev[SLC_EVT_TX]) & ~blink);
      end
      SLC_SRC_RXTX_ERR: lvl = ev[SLC_EVT_RXERR] | ev[SLC_EVT_TXERR];
      SLC_SRC_RX_ERR: lvl = ev[SLC_EVT_RXERR];
      default: lvl = 1'b0;
    endcase
    src_level = lvl;
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      source_select_q <= SLC_RST_SOURCE_SELECT;
    end else if (reg_wr && reg_addr == SLC_OFS_SOURCE_SELECT) begin
      source_select_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_force_q <= SLC_RST_POL_FORCE;
    end else if (reg_wr && reg_addr == SLC_OFS_POL_FORCE) begin
      pol_force_q <= reg_wdata & SLC_WMASK_POL_FORCE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_stretch_q <= SLC_RST_BLINK_STRETCH;
    end else if (reg_wr && reg_addr == SLC_OFS_BLINK_STRETCH) begin
      blink_stretch_q <= reg_wdata & SLC_WMASK_BLINK_STRETCH;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        SLC_OFS_SOURCE_SELECT: rdata_q <= source_select_q;
        SLC_OFS_POL_FORCE: rdata_q <= pol_force_q;
        SLC_OFS_BLINK_STRETCH: rdata_q <= blink_stretch_q;
        SLC_OFS_PIN_STATUS: rdata_q <= {12'h000, pin_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Blink timer
  // ----------------------------------------------------------------
  assign pulse_stretch_bypass = blink_stretch_q[SLC_STRETCH_BYPASS_BIT];
  assign blink_period_select = blink_stretch_q[SLC_BLINK_RATE_LSB +: 2];

  always_comb begin
    case (blink_period_select)
      2'h0: period_cyc = CNT_W'(BLINK_CYC_20HZ);
      2'h1: period_cyc = CNT_W'(BLINK_CYC_10HZ);
      2'h2: period_cyc = CNT_W'(BLINK_CYC_5HZ);
      default: period_cyc = CNT_W'(BLINK_CYC_2HZ);
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_q <= '0;
    end else if (tmr_q >= period_cyc - 1'b1) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  assign blink_wave = tmr_q < (period_cyc >> 1);

  // ----------------------------------------------------------------
  // Activity stretching
  // ----------------------------------------------------------------
  assign evt_raw = {tx_error, rx_error, collision, tx_activity, rx_activity};
  assign link_ok = link_up_1000 | link_up_100 | link_up_10;
  assign status_vec = {copper_link, full_duplex, link_up_10, link_up_100, link_up_1000};

  for (genvar e = 0; e < SLC_NUM_EVT; e++) begin : g_evt
    slc_stretch #(
      .CNT_W(CNT_W)
    ) u_stretch (
      .clk(clk),
      .rst_b(rst_b),
      .event_in(evt_raw[e]),
      .bypass(pulse_stretch_bypass),
      .hold_cyc(period_cyc),
      .stretched(evt_str[e])
    );
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  always_comb begin
    logic on;
    on = 1'b0;
    for (int unsigned i = 0; i < SLC_NUM_OUT; i++) begin
      on = src_level(source_select_q[i * SLC_FIELD_STRIDE +: 4], link_ok, status_vec,
                     evt_str, blink_wave);
      if (nib_bit(pol_force_q, i, SLC_FORCE_EN_OFS)) begin
        pin_d[i] = nib_bit(pol_force_q, i, SLC_FORCE_VAL_OFS);
      end else begin
        pin_d[i] = nib_bit(pol_force_q, i, SLC_ACTIVE_LVL_OFS) ~^ on;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 4'h0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign indicator_zero_pin = pin_q[0];
  assign indicator_one_pin = pin_q[1];
  assign indicator_two_pin = pin_q[2];
  assign aux_indicator_pin = pin_q[3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] hold_seen_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_seen_q <= 4'h0;
    end else if (rx_activity) begin
      hold_seen_q <= 4'h1;
    end else if (hold_seen_q != 4'h0 && hold_seen_q != 4'hF) begin
      hold_seen_q <= hold_seen_q + 4'h1;
    end
  end

  property p_aux_level;
    @(posedge clk) disable iff (!rst_b)
      !pol_force_q[12] |=> aux_indicator_pin ==
        ($past(pol_force_q[14]) ~^ $past(src_level(source_select_q[15:12], link_ok,
                                                   status_vec, evt_str, blink_wave)));
  endproperty
  a_aux_level: assert property (p_aux_level) else $error("aux level wrong");

  property p_aux_force;
    @(posedge clk) disable iff (!rst_b)
      pol_force_q[12] |=> aux_indicator_pin == $past(pol_force_q[13]);
  endproperty
  a_aux_force: assert property (p_aux_force) else $error("aux force wrong");

  property p_two_level;
    @(posedge clk) disable iff (!rst_b)
      (!pol_force_q[8] && source_select_q[11:8] == SLC_SRC_LINK_1000
       && link_up_1000) |=> indicator_two_pin == $past(pol_force_q[10]);
  endproperty
  a_two_level: assert property (p_two_level) else $error("two level wrong");

  property p_two_force;
    @(posedge clk) disable iff (!rst_b)
      pol_force_q[8] |=> indicator_two_pin == $past(pol_force_q[9]);
  endproperty
  a_two_force: assert property (p_two_force) else $error("two force wrong");

  property p_one_level;
    @(posedge clk) disable iff (!rst_b)
      (!pol_force_q[4] && source_select_q[7:4] == SLC_SRC_FULL_DUPLEX)
        |=> indicator_one_pin == ($past(pol_force_q[6]) ~^ $past(full_duplex));
  endproperty
  a_one_level: assert property (p_one_level) else $error("one level wrong");

  property p_one_force;
    @(posedge clk) disable iff (!rst_b)
      pol_force_q[4] |=> indicator_one_pin == $past(pol_force_q[5]);
  endproperty
  a_one_force: assert property (p_one_force) else $error("one force wrong");

  property p_zero_level;
    @(posedge clk) disable iff (!rst_b)
      (!pol_force_q[0] && source_select_q[3:0] == SLC_SRC_LINK_OK)
        |=> indicator_zero_pin == ($past(pol_force_q[2]) ~^ $past(link_ok));
  endproperty
  a_zero_level: assert property (p_zero_level) else $error("zero level wrong");

  property p_zero_force;
    @(posedge clk) disable iff (!rst_b)
      pol_force_q[0] ##1 pol_force_q[0] |-> indicator_zero_pin == $past(pol_force_q[1]);
  endproperty
  a_zero_force: assert property (p_zero_force) else $error("zero force wrong");

  property p_bypass;
    @(posedge clk) disable iff (!rst_b)
      pulse_stretch_bypass |-> evt_str == evt_raw;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not raw");

  property p_timer_bound;
    @(posedge clk) disable iff (!rst_b)
      $stable(blink_period_select) |-> tmr_q < period_cyc;
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("timer past period");

  property p_stretch_hold;
    @(posedge clk) disable iff (!rst_b)
      (rx_activity && !pulse_stretch_bypass && period_cyc > CNT_W'(8)
       && $stable(pulse_stretch_bypass)) |=> evt_str[SLC_EVT_RX] [*7];
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("stretch short");

  property p_gig_code;
    @(posedge clk) disable iff (!rst_b)
      (!pol_force_q[12] && source_select_q[15:12] == SLC_SRC_LINK_1000
       && pol_force_q[14]) |=> aux_indicator_pin == $past(link_up_1000);
  endproperty
  a_gig_code: assert property (p_gig_code) else $error("gigabit code wrong");

  c_force_aux: cover property (@(posedge clk) disable iff (!rst_b)
    pol_force_q[12] ##1 aux_indicator_pin);
  c_stretch: cover property (@(posedge clk) disable iff (!rst_b)
    hold_seen_q == 4'h8 && evt_str[SLC_EVT_RX]);
  c_blink: cover property (@(posedge clk) disable iff (!rst_b)
    blink_wave ##1 !blink_wave);
  c_active_low: cover property (@(posedge clk) disable iff (!rst_b)
    !pol_force_q[2] ##1 !indicator_zero_pin);

endmodule

// ---- rtl/slc_pkg.sv ----
// Constants shared by the status indicator output control block
package slc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned SLC_ADDR_W = 5;
  localparam int unsigned SLC_DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] SLC_OFS_SOURCE_SELECT = 5'h18;
  localparam logic [4:0] SLC_OFS_POL_FORCE = 5'h19;
  localparam logic [4:0] SLC_OFS_BLINK_STRETCH = 5'h1A;
  localparam logic [4:0] SLC_OFS_PIN_STATUS = 5'h1B;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] SLC_RST_SOURCE_SELECT = 16'h6000;
  localparam logic [15:0] SLC_RST_POL_FORCE = 16'h4444;
  localparam logic [15:0] SLC_RST_BLINK_STRETCH = 16'h0002;
  localparam logic [15:0] SLC_WMASK_POL_FORCE = 16'h7777;
  localparam logic [15:0] SLC_WMASK_BLINK_STRETCH = 16'h0007;

  // ----------------------------------------------------------------
  // Field layout: one nibble per output, aux output in the top nibble
  // ----------------------------------------------------------------
  localparam int unsigned SLC_NUM_OUT = 4;
  localparam int unsigned SLC_FIELD_STRIDE = 4;
  localparam int unsigned SLC_FORCE_EN_OFS = 0;
  localparam int unsigned SLC_FORCE_VAL_OFS = 1;
  localparam int unsigned SLC_ACTIVE_LVL_OFS = 2;
  localparam int unsigned SLC_STRETCH_BYPASS_BIT = 2;
  localparam int unsigned SLC_BLINK_RATE_LSB = 0;

  // ----------------------------------------------------------------
  // Source select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SLC_SRC_LINK_OK = 4'h0;
  localparam logic [3:0] SLC_SRC_RXTX_ACT = 4'h1;
  localparam logic [3:0] SLC_SRC_TX_ACT = 4'h2;
  localparam logic [3:0] SLC_SRC_RX_ACT = 4'h3;
  localparam logic [3:0] SLC_SRC_COLLISION = 4'h4;
  localparam logic [3:0] SLC_SRC_LINK_1000 = 4'h5;
  localparam logic [3:0] SLC_SRC_LINK_100 = 4'h6;
  localparam logic [3:0] SLC_SRC_LINK_10 = 4'h7;
  localparam logic [3:0] SLC_SRC_LINK_10_100 = 4'h8;
  localparam logic [3:0] SLC_SRC_LINK_100_1000 = 4'h9;
  localparam logic [3:0] SLC_SRC_FULL_DUPLEX = 4'hA;
  localparam logic [3:0] SLC_SRC_COPPER_BLINK = 4'hB;
  localparam logic [3:0] SLC_SRC_RXTX_ERR = 4'hD;
  localparam logic [3:0] SLC_SRC_RX_ERR = 4'hE;

  // ----------------------------------------------------------------
  // Activity event indices (stretched events)
  // ----------------------------------------------------------------
  localparam int unsigned SLC_NUM_EVT = 5;
  localparam int unsigned SLC_EVT_RX = 0;
  localparam int unsigned SLC_EVT_TX = 1;
  localparam int unsigned SLC_EVT_COL = 2;
  localparam int unsigned SLC_EVT_RXERR = 3;
  localparam int unsigned SLC_EVT_TXERR = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SLC_CLK_HZ = 25_000_000;
  localparam int unsigned SLC_BLINK_MS_20HZ = 50;
  localparam int unsigned SLC_BLINK_MS_10HZ = 100;
  localparam int unsigned SLC_BLINK_MS_5HZ = 200;
  localparam int unsigned SLC_BLINK_MS_2HZ = 500;
  localparam int unsigned SLC_CYC_20HZ = SLC_CLK_HZ / 1000 * SLC_BLINK_MS_20HZ;
  localparam int unsigned SLC_CYC_10HZ = SLC_CLK_HZ / 1000 * SLC_BLINK_MS_10HZ;
  localparam int unsigned SLC_CYC_5HZ = SLC_CLK_HZ / 1000 * SLC_BLINK_MS_5HZ;
  localparam int unsigned SLC_CYC_2HZ = SLC_CLK_HZ / 1000 * SLC_BLINK_MS_2HZ;
  localparam int unsigned SLC_CNT_W = 24;

endpackage

// ---- rtl/slc_stretch.sv ----
// Pulse stretcher for one activity event
`timescale 1ns/10ps
module slc_stretch #(
  parameter int unsigned CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic event_in,
  input wire logic bypass,
  input wire logic [CNT_W-1:0] hold_cyc,
  output logic stretched
);

  logic [CNT_W-1:0] hold_q;

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  // hold one period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
    end else if (event_in) begin
      hold_q <= hold_cyc - 1'b1;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  assign stretched = bypass ? event_in : (event_in | (hold_q != '0));

endmodule

// ---- sim/slc_led_board.sv ----
// Board-side model of the four indicator lamps: lit time of last pulse
`timescale 1ns/10ps
module slc_led_board (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] led_pin,
  output logic [3:0][15:0] lit_len
);
  logic [3:0][15:0] run_q;

  // ----------------------------------------------------------------
  // Lamp on-time measurement
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
      lit_len <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (led_pin[i]) begin
          run_q[i] <= run_q[i] + 16'h0001;
        end else begin
          run_q[i] <= 16'h0000;
          if (run_q[i] != 16'h0000) begin
            lit_len[i] <= run_q[i];
          end
        end
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the status indicator output control block
`timescale 1ns/10ps
module tb;
  import slc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic link_up_1000 = 1'b0;
  logic link_up_100 = 1'b1;
  logic link_up_10 = 1'b0;
  logic copper_link = 1'b0;
  logic full_duplex = 1'b0;
  logic [4:0] evt = 5'h00;
  logic [3:0] pins;
  logic [3:0][15:0] lit_len;
  logic [15:0] val;
  logic [3:0] nib;
  logic [3:0] exp4;
  int miscompares = 0;
  int total_checks = 0;
  int cyc [4] = '{16, 32, 64, 128};
  logic [3:0] nibs [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7};
  logic [3:0] evcode [5] = '{4'h3, 4'h2, 4'h4, 4'hE, 4'hD};

  always #20 clk = ~clk;

  slc_led_ctrl #(.BLINK_CYC_20HZ(16), .BLINK_CYC_10HZ(32), .BLINK_CYC_5HZ(64),
    .BLINK_CYC_2HZ(128)) u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_up_1000(link_up_1000), .link_up_100(link_up_100), .link_up_10(link_up_10),
    .copper_link(copper_link), .full_duplex(full_duplex), .rx_activity(evt[SLC_EVT_RX]),
    .tx_activity(evt[SLC_EVT_TX]), .collision(evt[SLC_EVT_COL]),
    .rx_error(evt[SLC_EVT_RXERR]), .tx_error(evt[SLC_EVT_TXERR]),
    .indicator_zero_pin(pins[0]), .indicator_one_pin(pins[1]),
    .indicator_two_pin(pins[2]), .aux_indicator_pin(pins[3]));

  slc_led_board u_board (.clk(clk), .rst_b(rst_b), .led_pin(pins), .lit_len(lit_len));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk16(reg_rdata, e);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int e, input logic [15:0] len);
    @(posedge clk);
    evt[e] <= 1'b1;
    @(posedge clk);
    evt[e] <= 1'b0;
    #1;
    chk_pins(pins, 4'hF);
    repeat (150) @(posedge clk);
    #1;
    for (int j = 0; j < 4; j++) begin
      chk16(lit_len[j], len);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(SLC_OFS_POL_FORCE, 16'h4444);
    rd(SLC_OFS_BLINK_STRETCH, 16'h0002);
    rd(SLC_OFS_SOURCE_SELECT, 16'h6000);
    settle();
    chk_pins(pins, 4'hF);
    wr(SLC_OFS_POL_FORCE, 16'hFFFF);
    rd(SLC_OFS_POL_FORCE, 16'h7777);
    wr(SLC_OFS_BLINK_STRETCH, 16'hFFFF);
    rd(SLC_OFS_BLINK_STRETCH, 16'h0007);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    wr(SLC_OFS_BLINK_STRETCH, 16'h0002);
    $display("register test done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      link_up_100 <= s[0];
      for (int i = 0; i < 4; i++) begin
        for (int k = 0; k < 6; k++) begin
          nib = nibs[k];
          val = (16'h4444 & ~(16'h000F << (4 * i))) | ({12'h000, nib} << (4 * i));
          wr(SLC_OFS_POL_FORCE, val);
          rd(SLC_OFS_POL_FORCE, val);
          settle();
          exp4 = {4{s[0]}};
          exp4[i] = nib[0] ? nib[1] : (nib[2] ~^ s[0]);
          chk_pins(pins, exp4);
          rd(SLC_OFS_PIN_STATUS, {12'h000, exp4});
        end
      end
    end
    wr(SLC_OFS_POL_FORCE, 16'h4444);
    $display("polarity and force test done");
    @(posedge clk);
    link_up_1000 <= 1'b1;
    link_up_100 <= 1'b0;
    full_duplex <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(SLC_OFS_SOURCE_SELECT, {4{c[3:0]}});
      settle();
      val = 16'h0621;
      chk_pins(pins, {4{val[c]}});
    end
    @(posedge clk);
    copper_link <= 1'b1;
    wr(SLC_OFS_SOURCE_SELECT, 16'hBBBB);
    settle();
    chk_pins(pins, 4'hF);
    $display("source select test done");
    wr(SLC_OFS_BLINK_STRETCH, 16'h0000);
    for (int e = 0; e < 5; e++) begin
      wr(SLC_OFS_SOURCE_SELECT, {4{evcode[e]}});
      settle();
      pulse(e, 16'd16);
    end
    wr(SLC_OFS_SOURCE_SELECT, 16'h3333);
    for (int r = 0; r < 4; r++) begin
      wr(SLC_OFS_BLINK_STRETCH, 16'(r));
      pulse(SLC_EVT_RX, 16'(cyc[r]));
    end
    wr(SLC_OFS_BLINK_STRETCH, 16'h0004);
    pulse(SLC_EVT_RX, 16'd1);
    $display("stretch test done");
    results();
  end
endmodule
